// ===== rtl/sensor_hub_session_sequencer.sv
`timescale 1ns/100ps
// What this block does
// - A session starts only on a timer tick while run-enable is set.
// - Sequencer memory holds mailbox bits, a data region and a code region.
// - Sequencer runs a code segment only when its mailbox bit is set.
// - Engine writes mailbox bits; host writes code segments, and so can the sequencer port, which has no address check.
// - Each period the engine copies sequencer data to its memory and clears each word in the same cycle.
// - After mailbox setup the engine starts the sequencer and keeps running.
// - Engine polls the semaphore, then halts and sleeps until the next tick.
// - Sequencer wakes only via engine; engine wakes via timer.
// - Power manager wakes the sleeping engine on sensor or timer events.
// - In interrupt mode hardware stamps every sensor read by itself.
// - Eight captured stamps of eight bits each.
// - Main stamp is 30 bits for host, 24 bits for engine.
// - Stamps advance once per millisecond.
// - Sequencer memory is 1.5 K words of 18 bits.
// - Engine has 50 KB code, 16 KB data memory, runs at up to 10 MHz.
// - Each session engine fetches from address zero until a stop instruction.
// - Engine code memory is loaded by host only; only the engine fetch reads it.
module sensor_hub_session_sequencer #(
  parameter int unsigned MS_CYC = sh_pkg::MS_CYC,
  parameter int unsigned DATA_WORDS = sh_pkg::DATA_WORDS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tickPulse,
  input wire logic pmWake,
  input wire logic [sh_pkg::STAMPS-1:0] sensorIrq,
  input wire logic [sh_pkg::SMM_AW-1:0] seqAddr,
  input wire logic seqWrEn,
  input wire logic [sh_pkg::SMM_W-1:0] seqWrData,
  output logic [sh_pkg::SMM_W-1:0] seqRdData,
  output logic seqStart,
  output logic [sh_pkg::SMM_W-1:0] segRunMask,
  output logic engineAwake,
  output logic sessionBusy,
  output logic [sh_pkg::MAIN_TS_W-1:0] mainStamp,
  output logic [sh_pkg::ENG_TS_W-1:0] engStamp
);
  localparam int unsigned IW = $clog2(DATA_WORDS);

  // Memories: sequencer shared memory, engine code and engine data
  logic [sh_pkg::SMM_W-1:0] smm [sh_pkg::SMM_WORDS];
  logic [sh_pkg::CM_W-1:0] cm [sh_pkg::CM_WORDS];
  logic [sh_pkg::SMM_W-1:0] dm [sh_pkg::DM_WORDS];

  sh_pkg::state_t state_q, state_d;
  logic [IW-1:0] idx_q, idx_d;
  logic [sh_pkg::CM_AW-1:0] pc_q, pc_d;
  logic [4:0] stepCnt_q, stepCnt_d;
  logic stopSeen_q, stopSeen_d, semSeen_q, semSeen_d;
  logic awake_q, awake_d, start_q, start_d;
  logic step;
  logic engWe;
  logic [sh_pkg::SMM_AW-1:0] engAddr;
  logic [sh_pkg::SMM_W-1:0] engWdata;
  logic dmWe;
  logic [sh_pkg::DM_AW-1:0] dmWaddr;
  logic [sh_pkg::CM_W-1:0] instr;

  logic ctrlEn_q, ctrlEn_d, ctrlStamp_q, ctrlStamp_d;
  logic [sh_pkg::SMM_W-1:0] mbox_q, mbox_d;
  logic [sh_pkg::CM_AW-1:0] cmAddr_q, cmAddr_d;
  logic [sh_pkg::SMM_AW-1:0] smmAddr_q, smmAddr_d;
  logic [sh_pkg::DM_AW-1:0] dmAddr_q, dmAddr_d;
  logic [31:0] prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic access, take, wrTake, hostSmmWr, hostCmWr, portBusy, mapped;
  logic smmWe;
  logic [sh_pkg::SMM_AW-1:0] smmWaddr;
  logic [sh_pkg::SMM_W-1:0] smmWdata;
  logic [sh_pkg::SMM_W-1:0] seqRdData_d, segRunMask_d;
  logic [sh_pkg::STAMPS*sh_pkg::STAMP_W-1:0] stamps;

  // Register match against a byte offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  ms_stamp_timer #(.MS_CYC(MS_CYC)) uTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .mainStamp_q(mainStamp),
    .engStamp_q(engStamp)
  );

  irq_stamp_capture #(.NUM(sh_pkg::STAMPS)) uStamp (
    .clk_sys(clk_sys),
    .rst(rst),
    .sensorIrq(sensorIrq),
    .stampMode(ctrlStamp_q),
    .nowStamp(engStamp[sh_pkg::STAMP_W-1:0]),
    .stamps_q(stamps)
  );

  // Engine pacing: one instruction step per 100 ns keeps it within 10 MHz
  assign step = (stepCnt_q == 5'(sh_pkg::ENG_STEP_CYC - 1));
  assign instr = cm[pc_q];

  // Session sequence: tick plus enable, collect, mailbox, start, run and poll
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    pc_d = pc_q;
    stepCnt_d = step ? 5'h00 : stepCnt_q + 5'h01;
    stopSeen_d = stopSeen_q;
    semSeen_d = semSeen_q;
    awake_d = awake_q;
    start_d = 1'b0;
    engWe = 1'b0;
    engAddr = sh_pkg::SEM_IDX;
    engWdata = sh_pkg::SMM_CLEAR;
    dmWe = 1'b0;
    dmWaddr = sh_pkg::DM_AW'(idx_q);
    if (pmWake) begin
      awake_d = 1'b1;
    end
    unique case (state_q)
      sh_pkg::ST_SLEEP: begin
        if (tickPulse && ctrlEn_q) begin
          awake_d = 1'b1;
          idx_d = '0;
          state_d = sh_pkg::ST_COLLECT;
        end
      end
      sh_pkg::ST_COLLECT: begin
        engWe = 1'b1;
        engAddr = sh_pkg::DATA_LO + sh_pkg::SMM_AW'(idx_q);
        engWdata = sh_pkg::SMM_CLEAR;
        dmWe = 1'b1;
        idx_d = idx_q + IW'(1);
        if (idx_q == IW'(DATA_WORDS - 1)) begin
          state_d = sh_pkg::ST_MBOX;
        end
      end
      sh_pkg::ST_MBOX: begin
        engWe = 1'b1;
        engAddr = sh_pkg::MBOX_IDX;
        engWdata = mbox_q;
        state_d = sh_pkg::ST_START;
      end
      sh_pkg::ST_START: begin
        engWe = 1'b1;
        engAddr = sh_pkg::SEM_IDX;
        engWdata = sh_pkg::SMM_CLEAR;
        start_d = 1'b1;
        pc_d = '0;
        stopSeen_d = 1'b0;
        semSeen_d = 1'b0;
        stepCnt_d = 5'h00;
        state_d = sh_pkg::ST_RUN;
      end
      sh_pkg::ST_RUN: begin
        // Engine code runs alongside the sequencer session
        if (step) begin
          if (!stopSeen_q) begin
            if (instr[sh_pkg::OP_MSB:sh_pkg::OP_LSB] == sh_pkg::OP_STOP) begin
              stopSeen_d = 1'b1;
            end else begin
              pc_d = pc_q + sh_pkg::CM_AW'(1);
            end
          end
          semSeen_d = (smm[sh_pkg::SEM_IDX] == sh_pkg::SEM_TRUE);
        end
        if (stopSeen_q && semSeen_q) begin
          awake_d = 1'b0;
          state_d = sh_pkg::ST_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= sh_pkg::ST_SLEEP;
      idx_q <= '0;
      pc_q <= '0;
      stepCnt_q <= 5'h00;
      stopSeen_q <= 1'b0;
      semSeen_q <= 1'b0;
      awake_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      pc_q <= pc_d;
      stepCnt_q <= stepCnt_d;
      stopSeen_q <= stopSeen_d;
      semSeen_q <= semSeen_d;
      awake_q <= awake_d;
      start_q <= start_d;
    end
  end

  // Shared memory write port: engine first, then sequencer, then host.
  // The host never loses a write: its APB answer waits for a free port.
  assign portBusy = engWe | seqWrEn;
  always_comb begin
    smmWe = 1'b0;
    smmWaddr = smmAddr_q;
    smmWdata = pwdata[sh_pkg::SMM_W-1:0];
    if (engWe) begin
      smmWe = 1'b1;
      smmWaddr = engAddr;
      smmWdata = engWdata;
    end else if (seqWrEn) begin
      smmWe = 1'b1;
      smmWaddr = seqAddr;
      smmWdata = seqWrData;
    end else if (hostSmmWr) begin
      smmWe = 1'b1;
    end
    seqRdData_d = smm[seqAddr];
    segRunMask_d = smm[sh_pkg::MBOX_IDX];
  end

  // Memory arrays carry no reset; the host loads code memory and the code region before enabling
  always_ff @(posedge clk_sys) begin
    if (smmWe) begin
      smm[smmWaddr] <= smmWdata;
    end
    if (dmWe) begin
      dm[dmWaddr] <= smm[engAddr];
    end
    if (hostCmWr) begin
      cm[cmAddr_q] <= pwdata;
    end
  end

  // APB slave: answer registered, one wait state; SMM_DATA writes wait for the port
  assign access = psel & penable & ~pready_q;
  assign mapped = hit(paddr, sh_pkg::REG_CTRL) | hit(paddr, sh_pkg::REG_MBOX) |
    hit(paddr, sh_pkg::REG_STATUS) | hit(paddr, sh_pkg::REG_MAIN_TS) |
    hit(paddr, sh_pkg::REG_ENG_TS) | hit(paddr, sh_pkg::REG_CM_ADDR) |
    hit(paddr, sh_pkg::REG_CM_DATA) | hit(paddr, sh_pkg::REG_SMM_ADDR) |
    hit(paddr, sh_pkg::REG_SMM_DATA) | hit(paddr, sh_pkg::REG_DM_ADDR) |
    hit(paddr, sh_pkg::REG_DM_DATA) | hit(paddr, sh_pkg::REG_STAMP_LO) |
    hit(paddr, sh_pkg::REG_STAMP_HI);
  assign take = access & ~(pwrite & hit(paddr, sh_pkg::REG_SMM_DATA) & portBusy);
  assign wrTake = take & pwrite & mapped;
  // Host may only fill the code region of the shared memory
  assign hostSmmWr = wrTake & hit(paddr, sh_pkg::REG_SMM_DATA) &
    (smmAddr_q >= sh_pkg::CODE_LO);
  assign hostCmWr = wrTake & hit(paddr, sh_pkg::REG_CM_DATA);

  // Register next values and read mux
  always_comb begin
    ctrlEn_d = ctrlEn_q;
    ctrlStamp_d = ctrlStamp_q;
    mbox_d = mbox_q;
    cmAddr_d = cmAddr_q;
    smmAddr_d = smmAddr_q;
    dmAddr_d = dmAddr_q;
    pready_d = take;
    pslverr_d = take & ~mapped;
    prdata_d = 32'h00000000;
    if (wrTake) begin
      if (hit(paddr, sh_pkg::REG_CTRL)) begin
        ctrlEn_d = pwdata[sh_pkg::CTRL_EN_BIT];
        ctrlStamp_d = pwdata[sh_pkg::CTRL_STAMP_BIT];
      end
      if (hit(paddr, sh_pkg::REG_MBOX)) begin
        mbox_d = pwdata[sh_pkg::SMM_W-1:0];
      end
      if (hit(paddr, sh_pkg::REG_CM_ADDR)) begin
        cmAddr_d = pwdata[sh_pkg::CM_AW-1:0];
      end
      if (hostCmWr) begin
        cmAddr_d = cmAddr_q + sh_pkg::CM_AW'(1); // Auto-increment speeds code loads
      end
      if (hit(paddr, sh_pkg::REG_SMM_ADDR)) begin
        smmAddr_d = pwdata[sh_pkg::SMM_AW-1:0];
      end
      if (hit(paddr, sh_pkg::REG_SMM_DATA)) begin
        smmAddr_d = smmAddr_q + sh_pkg::SMM_AW'(1);
      end
      if (hit(paddr, sh_pkg::REG_DM_ADDR)) begin
        dmAddr_d = pwdata[sh_pkg::DM_AW-1:0];
      end
    end
    if (take && !pwrite) begin
      if (hit(paddr, sh_pkg::REG_CTRL)) begin
        prdata_d = {30'h00000000, ctrlStamp_q, ctrlEn_q};
      end
      if (hit(paddr, sh_pkg::REG_MBOX)) begin
        prdata_d = {14'h0000, mbox_q};
      end
      if (hit(paddr, sh_pkg::REG_STATUS)) begin
        prdata_d = {21'h000000, state_q, semSeen_q, stopSeen_q, start_q, seqWrEn,
          awake_q, 1'b0};
      end
      if (hit(paddr, sh_pkg::REG_MAIN_TS)) begin
        prdata_d = {2'h0, mainStamp};
      end
      if (hit(paddr, sh_pkg::REG_ENG_TS)) begin
        prdata_d = {8'h00, engStamp};
      end
      if (hit(paddr, sh_pkg::REG_CM_ADDR)) begin
        prdata_d = {18'h00000, cmAddr_q}; // Code words themselves are write-only
      end
      if (hit(paddr, sh_pkg::REG_SMM_ADDR)) begin
        prdata_d = {21'h000000, smmAddr_q};
      end
      if (hit(paddr, sh_pkg::REG_SMM_DATA)) begin
        prdata_d = {14'h0000, smm[smmAddr_q]};
      end
      if (hit(paddr, sh_pkg::REG_DM_ADDR)) begin
        prdata_d = {20'h00000, dmAddr_q};
      end
      if (hit(paddr, sh_pkg::REG_DM_DATA)) begin
        prdata_d = {14'h0000, dm[dmAddr_q]};
      end
      if (hit(paddr, sh_pkg::REG_STAMP_LO)) begin
        prdata_d = stamps[31:0];
      end
      if (hit(paddr, sh_pkg::REG_STAMP_HI)) begin
        prdata_d = stamps[63:32];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrlEn_q <= 1'b0;
      ctrlStamp_q <= 1'b0;
      mbox_q <= 18'h00000;
      cmAddr_q <= '0;
      smmAddr_q <= '0;
      dmAddr_q <= '0;
      prdata <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      seqRdData <= 18'h00000;
      segRunMask <= 18'h00000;
    end else begin
      ctrlEn_q <= ctrlEn_d;
      ctrlStamp_q <= ctrlStamp_d;
      mbox_q <= mbox_d;
      cmAddr_q <= cmAddr_d;
      smmAddr_q <= smmAddr_d;
      dmAddr_q <= dmAddr_d;
      prdata <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      seqRdData <= seqRdData_d;
      segRunMask <= segRunMask_d;
    end
  end

  // Outputs straight from flops; sessionBusy is the inverted sleep-state bit
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign seqStart = start_q;
  assign engineAwake = awake_q;
  assign sessionBusy = ~state_q[0];
endmodule

// ===== rtl/sh_pkg.sv
package sh_pkg;

  // Clock and pacing figures
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ENG_PERIOD_NS = 100;
  localparam int unsigned ENG_STEP_CYC = (ENG_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYC = MS_NS / CLK_PERIOD_NS;

  // Sequencer memory: 1.5 K words of 18 bits in three regions
  localparam int unsigned SMM_WORDS = 1536;
  localparam int unsigned SMM_W = 18;
  localparam int unsigned SMM_AW = 11;
  localparam logic [10:0] MBOX_IDX = 11'h000;
  localparam logic [10:0] SEM_IDX = 11'h001;
  localparam logic [10:0] DATA_LO = 11'h002;
  localparam logic [10:0] CODE_LO = 11'h022;
  localparam int unsigned DATA_WORDS = 32;
  localparam logic [17:0] SEM_TRUE = 18'h00001;
  localparam logic [17:0] SMM_CLEAR = 18'h00000;

  // Engine memories: 50 KB code in 32-bit words, 16 KB data in 18-bit words
  localparam int unsigned CM_BYTES = 51200;
  localparam int unsigned CM_W = 32;
  localparam int unsigned CM_WORDS = CM_BYTES / 4;
  localparam int unsigned CM_AW = 14;
  localparam int unsigned DM_BYTES = 16384;
  localparam int unsigned DM_WORDS = DM_BYTES / 4;
  localparam int unsigned DM_AW = 12;
  localparam int unsigned OP_MSB = 31;
  localparam int unsigned OP_LSB = 24;
  localparam logic [7:0] OP_STOP = 8'hff;

  // Time stamps
  localparam int unsigned STAMPS = 8;
  localparam int unsigned STAMP_W = 8;
  localparam int unsigned MAIN_TS_W = 30;
  localparam int unsigned ENG_TS_W = 24;

  // APB register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_MBOX = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_MAIN_TS = 12'h00c;
  localparam logic [11:0] REG_ENG_TS = 12'h010;
  localparam logic [11:0] REG_CM_ADDR = 12'h014;
  localparam logic [11:0] REG_CM_DATA = 12'h018;
  localparam logic [11:0] REG_SMM_ADDR = 12'h01c;
  localparam logic [11:0] REG_SMM_DATA = 12'h020;
  localparam logic [11:0] REG_DM_ADDR = 12'h024;
  localparam logic [11:0] REG_DM_DATA = 12'h028;
  localparam logic [11:0] REG_STAMP_LO = 12'h02c;
  localparam logic [11:0] REG_STAMP_HI = 12'h030;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_STAMP_BIT = 1;

  // Session states, one-hot
  typedef enum logic [4:0] {
    ST_SLEEP = 5'b00001,
    ST_COLLECT = 5'b00010,
    ST_MBOX = 5'b00100,
    ST_START = 5'b01000,
    ST_RUN = 5'b10000
  } state_t;

endpackage

// ===== rtl/ms_stamp_timer.sv
`timescale 1ns/100ps
// Millisecond prescaler and main time-stamp counter
module ms_stamp_timer #(
  parameter int unsigned MS_CYC = sh_pkg::MS_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic [sh_pkg::MAIN_TS_W-1:0] mainStamp_q,
  output logic [sh_pkg::ENG_TS_W-1:0] engStamp_q
);
  logic [31:0] preCnt_q, preCnt_d;
  logic [sh_pkg::MAIN_TS_W-1:0] mainStamp_d;
  logic [sh_pkg::ENG_TS_W-1:0] engStamp_d;

  // One count per millisecond; both views come from one counter so they never disagree
  always_comb begin
    preCnt_d = preCnt_q + 32'h00000001;
    mainStamp_d = mainStamp_q;
    if (preCnt_q == 32'(MS_CYC - 1)) begin
      preCnt_d = 32'h00000000;
      mainStamp_d = mainStamp_q + 30'h00000001;
    end
    engStamp_d = mainStamp_d[sh_pkg::ENG_TS_W-1:0];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      preCnt_q <= 32'h00000000;
      mainStamp_q <= 30'h00000000;
      engStamp_q <= 24'h000000;
    end else begin
      preCnt_q <= preCnt_d;
      mainStamp_q <= mainStamp_d;
      engStamp_q <= engStamp_d;
    end
  end
endmodule

// ===== rtl/irq_stamp_capture.sv
`timescale 1ns/100ps
// Captures a stamp on each sensor interrupt rising edge while interrupt mode is on
module irq_stamp_capture #(
  parameter int unsigned NUM = sh_pkg::STAMPS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM-1:0] sensorIrq,
  input wire logic stampMode,
  input wire logic [sh_pkg::STAMP_W-1:0] nowStamp,
  output logic [NUM*sh_pkg::STAMP_W-1:0] stamps_q
);
  logic [NUM-1:0] sync1_q, sync2_q, sync3_q, level_q, level_d;
  logic [NUM*sh_pkg::STAMP_W-1:0] stamps_d;

  // Pins come from outside; a change counts once the second and third stages agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= sensorIrq;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Rising edge of a filtered level takes a stamp, no software involved
  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : gCap
      always_comb begin
        level_d[g] = level_q[g];
        if (sync2_q[g] == sync3_q[g]) begin
          level_d[g] = sync3_q[g];
        end
        stamps_d[g*sh_pkg::STAMP_W +: sh_pkg::STAMP_W] =
          stamps_q[g*sh_pkg::STAMP_W +: sh_pkg::STAMP_W];
        if (stampMode && level_d[g] && !level_q[g]) begin
          stamps_d[g*sh_pkg::STAMP_W +: sh_pkg::STAMP_W] = nowStamp;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level_q <= '0;
      stamps_q <= '0;
    end else begin
      level_q <= level_d;
      stamps_q <= stamps_d;
    end
  end
endmodule

// ===== dv/sh_chk.sv
`timescale 1ns/100ps
// Port-level checker for the session sequencer
module sh_chk #(
  parameter int unsigned MS_CYC = 10,
  parameter int unsigned DATA_WORDS = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic tickPulse,
  input wire logic seqStart,
  input wire logic engineAwake,
  input wire logic sessionBusy,
  input wire logic [sh_pkg::MAIN_TS_W-1:0] mainStamp,
  input wire logic [sh_pkg::ENG_TS_W-1:0] engStamp
);
  localparam int LO = DATA_WORDS + 1;
  localparam int HI = DATA_WORDS + 3;
  localparam int PER = MS_CYC - 1;
  logic [31:0] gapCnt_q, gapCnt_d;
  logic [sh_pkg::MAIN_TS_W-1:0] prevStamp_q;
  logic seen_q, seen_d, stepped;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles between stamp steps; the first step has no known phase, so it is not judged
  always_comb begin
    stepped = mainStamp != prevStamp_q;
    gapCnt_d = stepped ? 32'h0 : gapCnt_q + 32'h1;
    seen_d = seen_q | stepped;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gapCnt_q <= 32'h0;
      seen_q <= 1'b0;
      prevStamp_q <= '0;
    end else begin
      gapCnt_q <= gapCnt_d;
      seen_q <= seen_d;
      prevStamp_q <= mainStamp;
    end
  end
  a_start_pulse: assert property (seqStart |=> !seqStart)
    else $error("start lasted over one cycle");
  a_start_busy: assert property (seqStart |-> sessionBusy && engineAwake)
    else $error("start outside an awake session");
  a_idle_hold: assert property (!sessionBusy && !tickPulse |=> !sessionBusy)
    else $error("session began without a tick");
  a_collect_first: assert property ($rose(sessionBusy) |-> ##[LO:HI] seqStart)
    else $error("start not after collection");
  a_sleep_drop: assert property ($fell(sessionBusy) |-> ##[0:1] !engineAwake)
    else $error("engine stayed awake after halt");
  a_stamp_step: assert property (stepped |-> mainStamp == prevStamp_q + 30'h1)
    else $error("stamp did not step by one");
  a_stamp_period: assert property (stepped && seen_q |-> gapCnt_q == PER)
    else $error("stamp period wrong");
  a_stamp_split: assert property (engStamp == mainStamp[23:0])
    else $error("engine stamp differs from main stamp");
  a_code_hidden: assert property (pready && !pwrite && paddr == sh_pkg::REG_CM_DATA
    |-> prdata == 32'h0)
    else $error("code memory read back");
  c_start: cover property (seqStart);
  c_sleep: cover property ($fell(sessionBusy));
  c_step: cover property (stepped && seen_q);
endmodule

bind sensor_hub_session_sequencer sh_chk #(.MS_CYC(MS_CYC), .DATA_WORDS(DATA_WORDS)) sh_chk_i (
  .clk_sys, .rst, .paddr, .pwrite, .prdata, .pready, .tickPulse, .seqStart, .engineAwake,
  .sessionBusy, .mainStamp, .engStamp
);

// ===== dv/sensor_seq_model.sv
`timescale 1ns/100ps
// Behavioural sensor sequencer on the far side of the shared memory port
module sensor_seq_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic seqStart,
  input wire logic [17:0] segRunMask,
  input wire logic [17:0] seqRdData,
  input wire logic [7:0] lag,
  output logic [10:0] seqAddr,
  output logic seqWrEn,
  output logic [17:0] seqWrData,
  output logic [17:0] dataSeen,
  output logic [17:0] semSeen
);
  // One-cycle write strobe per word
  task automatic put(input logic [10:0] a, input logic [17:0] d);
    @(posedge clk_sys);
    seqAddr <= a;
    seqWrEn <= 1'b1;
    seqWrData <= d;
  endtask
  // Reads back data and flag, waits lag cycles, runs selected segments, raises the flag
  initial begin
    seqAddr = '0;
    seqWrEn = 1'b0;
    seqWrData = 18'h15555;
    dataSeen = '0;
    semSeen = '0;
    forever begin
      @(posedge clk_sys);
      seqWrData <= ~seqWrData;  // Idle data keeps moving so no stale word looks valid
      if (seqStart === 1'b1 && rst === 1'b0) begin
        seqAddr <= sh_pkg::DATA_LO;
        @(posedge clk_sys);
        seqAddr <= sh_pkg::SEM_IDX;
        @(posedge clk_sys);
        dataSeen <= seqRdData;
        @(posedge clk_sys);
        semSeen <= seqRdData;
        repeat (lag) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
          if (segRunMask[i]) begin
            put(sh_pkg::DATA_LO + 11'(i), 18'h000a0 + 18'(i));
          end
        end
        put(sh_pkg::SEM_IDX, sh_pkg::SEM_TRUE);
        @(posedge clk_sys);
        seqWrEn <= 1'b0;  // Halted until the next start
      end
    end
  end
endmodule

// ===== dv/tb.sv
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED at %0t: %s", $time, msg); end end
// Host over APB, tick and interrupt pins, against the behavioural sequencer
module tb;
  localparam int unsigned MSC = 10;
  localparam int unsigned DW = 4;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, tickPulse, pmWake, err;
  logic seqWrEn, seqStart, engineAwake, sessionBusy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] sensorIrq, lag, e;
  logic [10:0] seqAddr;
  logic [17:0] seqWrData, seqRdData, segRunMask, dataSeen, semSeen;
  logic [29:0] mainStamp;
  logic [23:0] engStamp;
  int n_fail, checked, starts, cyc;
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  sensor_hub_session_sequencer #(.MS_CYC(MSC), .DATA_WORDS(DW)) sensor_hub_session_sequencer_i (
    .clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tickPulse(tickPulse), .pmWake(pmWake), .sensorIrq(sensorIrq), .seqAddr(seqAddr),
    .seqWrEn(seqWrEn), .seqWrData(seqWrData), .seqRdData(seqRdData), .seqStart(seqStart),
    .segRunMask(segRunMask), .engineAwake(engineAwake), .sessionBusy(sessionBusy),
    .mainStamp(mainStamp), .engStamp(engStamp));
  sensor_seq_model sensor_seq_model_i (.clk_sys(clk_sys), .rst(rst), .seqStart(seqStart),
    .segRunMask(segRunMask), .seqRdData(seqRdData), .lag(lag), .seqAddr(seqAddr),
    .seqWrEn(seqWrEn), .seqWrData(seqWrData), .dataSeen(dataSeen), .semSeen(semSeen));
  task automatic conclude();
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Start counter and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (seqStart === 1'b1) begin
      starts++;
    end
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end
  // One APB transfer; holds everything until pready is sampled high, only the hang guard ends it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    tickPulse <= 1'b1;
    @(posedge clk_sys);
    tickPulse <= 1'b0;
  endtask
  // Full session; a second tick mid-session must be ignored
  task automatic session(input logic [7:0] slow);
    int n;
    n = 0;
    lag <= slow;
    tick();
    while (seqStart !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    `CHK(segRunMask, 18'h00005, "mailbox bits not presented")
    tick();
    n = 0;
    while (sessionBusy !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(sessionBusy, 1'b0, "engine never slept")
    `CHK(semSeen, 18'h0, "flag true at session start")
  endtask
  initial begin
    {rst, psel, penable, pwrite, tickPulse, pmWake} = 6'b100000;
    {paddr, pwdata, sensorIrq, lag} = '0;
    {n_fail, checked, starts, cyc} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK({seqStart, sessionBusy, engineAwake}, 3'b000, "outputs busy after reset")
    apb(1'b0, sh_pkg::REG_CTRL, 32'h0);
    `CHK(rd, 32'h0, "enable set after reset")
    apb(1'b0, 12'h100, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read accepted")
    apb(1'b1, sh_pkg::REG_CM_ADDR, 32'h0);
    apb(1'b1, sh_pkg::REG_CM_DATA, 32'hff000000);  // Stop word at address zero
    apb(1'b1, sh_pkg::REG_CM_ADDR, 32'h0);
    apb(1'b0, sh_pkg::REG_CM_DATA, 32'h0);
    `CHK(rd, 32'h0, "code memory readable")
    apb(1'b1, sh_pkg::REG_SMM_ADDR, {21'h0, sh_pkg::CODE_LO});
    apb(1'b1, sh_pkg::REG_SMM_DATA, 32'h00001234);  // Host loads a code segment
    apb(1'b1, sh_pkg::REG_MBOX, 32'h00000005);
    tick();
    repeat (4) @(posedge clk_sys);
    `CHK(sessionBusy, 1'b0, "tick without enable started")
    @(posedge clk_sys);
    pmWake <= 1'b1;
    @(posedge clk_sys);
    pmWake <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK({engineAwake, sessionBusy}, 2'b10, "wake event misbehaved")
    apb(1'b1, sh_pkg::REG_CTRL, 32'h1);
    repeat (4) @(posedge clk_sys);
    `CHK(sessionBusy, 1'b0, "enable alone started")
    session(8'd0);
    apb(1'b1, sh_pkg::REG_SMM_ADDR, 32'h00000003);
    apb(1'b1, sh_pkg::REG_SMM_DATA, 32'h0003ffff);  // Data region is not host writable
    session(8'd60);
    `CHK(dataSeen, 18'h0, "data region not cleared")
    `CHK(starts, 2, "stray or missing start")
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, sh_pkg::REG_DM_ADDR, 32'(i));
      apb(1'b0, sh_pkg::REG_DM_DATA, 32'h0);
      `CHK(rd, (i == 1) ? 32'h0 : 32'h000000a0 + 32'(i), "collected data wrong")
    end
    apb(1'b1, sh_pkg::REG_CTRL, 32'h3);
    e = engStamp[7:0];
    while (engStamp[7:0] === e) begin
      @(posedge clk_sys);
    end
    sensorIrq <= 8'hff;
    e = engStamp[7:0];
    repeat (6) @(posedge clk_sys);
    apb(1'b0, sh_pkg::REG_STAMP_LO, 32'h0);
    `CHK(rd, {4{e}}, "low stamps wrong")
    apb(1'b0, sh_pkg::REG_STAMP_HI, 32'h0);
    `CHK(rd, {4{e}}, "high stamps wrong")
    apb(1'b1, sh_pkg::REG_CTRL, 32'h1);
    sensorIrq <= 8'h00;
    repeat (25) @(posedge clk_sys);
    sensorIrq <= 8'h01;
    repeat (8) @(posedge clk_sys);
    apb(1'b0, sh_pkg::REG_STAMP_LO, 32'h0);
    `CHK(rd, {4{e}}, "stamp taken outside interrupt mode")
    conclude();
  end
endmodule
